// ---- src/afs_pkg.sv ----
// Shared constants and types for the AFE serial host interface
package afs_pkg;
	localparam int          CTRL_BITS      = 8;
	localparam int          REG_COUNT      = 32;
	localparam int          WORD_MAX       = 32;
	localparam logic [1:0]  DEV_ADDR_RST   = 2'h1;
	localparam logic [7:0]  KEY_PASSWORD   = 8'hA5;
	localparam logic [7:0]  KEY_RST        = 8'hA5;
	localparam logic [4:0]  ADDR_KEY_CRC   = 5'h1F;
	localparam logic [4:0]  ADDR_STATUS_AND_COMM_SETTINGS = 5'h0A;
	localparam logic [4:0]  ADDR_MODOUT    = 5'h08;
	localparam logic [4:0]  ADDR_FIRST_WR  = 5'h08;
	localparam logic [4:0]  ADDR_LAST_ADC  = 5'h07;
	localparam logic [15:0] CRC_POLY       = 16'h8005;
	localparam logic [15:0] CRC_SEED       = 16'h0000;
	// Settings word fields
	localparam int          POS_READ       = 22;
	localparam int          POS_WRITE      = 21;
	localparam int          POS_WIDTH      = 16;
	localparam int          POS_CRC_EN     = 15;
	localparam int          POS_ALERT_EN   = 14;
	localparam logic [23:0] STATUS_AND_COMM_SETTINGS_RST  = 24'hA1_0000;
	localparam logic [23:0] ADC_STEP       = 24'h00_0101;
	// Word width codes: 00 16-bit, 01 24-bit, 1x 32-bit
	localparam logic [1:0]  WIDTH_16       = 2'h0;
	localparam logic [1:0]  WIDTH_24       = 2'h1;
	typedef enum logic [1:0] {READ_STATIC, READ_GROUP, READ_TYPE, READ_FULL} afs_read_t;
endpackage : afs_pkg

// ---- src/afs_if.sv ----
// Four-wire serial link between host and device plus side pins
interface afs_if;
	logic sck;
	logic cs_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic data_ready_pin_n;
	logic reset_pin;
	modport device (input sck, cs_n, sdi, reset_pin, output sdo, sdo_oe, data_ready_pin_n);
	modport host (output sck, cs_n, sdi, reset_pin, input sdo, sdo_oe, data_ready_pin_n);
endinterface : afs_if

// ---- src/afs_device.sv ----
// Device end: serial slave, register file, key lock, checksums, ready pin
module afs_device #(
	parameter int READY_PERIOD = 400
) (
	// Core clock and reset
	input  wire logic I_CORE_CLK,
	input  wire logic I_RESET,
	// ADC results and new-result strobe
	input  wire logic [23:0] I_ADC_DATA [8],
	input  wire logic        I_ADC_NEW,
	// Link
	afs_if.device            LINK
);
	typedef enum {ST_CTRL, ST_READ, ST_WRITE, ST_IDLE} afs_state_t;
	afs_state_t  state_reg;
	logic [2:0]  sck_s_reg, cs_s_reg;
	logic [1:0]  sdi_s_reg;
	logic [1:0]  rst_s_reg;
	logic [23:0] regs_reg [32];
	logic [7:0]  key_reg;
	logic [5:0]  bit_cnt_reg;
	logic [31:0] shift_reg;
	logic [4:0]  addr_reg;
	logic [15:0] crc_reg, crc_next, cfg_crc_reg, cfg_crc_prev_reg, rd_crc_reg;
	logic        crc_phase_reg;
	logic        alert_reg;
	logic        ready_pulse_reg;
	logic        sdo_reg, oe_reg;
	logic        hard_rst;
	logic        sck_rise, sck_fall, cs_rise, cs_low;
	logic [5:0]  word_bits;
	logic [23:0] sc;

	function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic d);
		crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ d) ? afs_pkg::CRC_POLY : 16'h0000);
	endfunction : crc_bit

	// Set of the index: first and last address
	function automatic logic [4:0] next_addr(input logic [4:0] a, input logic [1:0] m);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = 5'h00;
		hi = 5'h1F;
		case (m)
			2'h0: begin
				lo = a;
				hi = a;
			end
			2'h1: begin
				lo = {a[4:1], 1'b0};
				hi = {a[4:1], 1'b1};
			end
			2'h2: begin
				lo = (a <= afs_pkg::ADDR_LAST_ADC) ? 5'h00 : afs_pkg::ADDR_FIRST_WR;
				hi = (a <= afs_pkg::ADDR_LAST_ADC) ? afs_pkg::ADDR_LAST_ADC : 5'h1F;
			end
			default: begin
				lo = 5'h00;
				hi = 5'h1F;
			end
		endcase
		next_addr = (a == hi) ? lo : a + 5'h01;
	endfunction : next_addr

	assign sc        = regs_reg[afs_pkg::ADDR_STATUS_AND_COMM_SETTINGS];
	assign hard_rst  = I_RESET | rst_s_reg[1];
	assign sck_rise  = sck_s_reg[1] & ~sck_s_reg[2];
	assign sck_fall  = ~sck_s_reg[1] & sck_s_reg[2];
	assign cs_rise   = cs_s_reg[1] & ~cs_s_reg[2];
	assign cs_low    = ~cs_s_reg[1];
	assign word_bits = (sc[afs_pkg::POS_WIDTH +: 2] == afs_pkg::WIDTH_16) ? 6'd16 :
		(sc[afs_pkg::POS_WIDTH +: 2] == afs_pkg::WIDTH_24) ? 6'd24 : 6'd32;

	// Two-stage synchronisers; third stage only for edge finding
	always_ff @(posedge I_CORE_CLK) begin
		sck_s_reg <= {sck_s_reg[1:0], LINK.sck};
		cs_s_reg  <= {cs_s_reg[1:0], LINK.cs_n};
		sdi_s_reg <= {sdi_s_reg[0], LINK.sdi};
		rst_s_reg <= {rst_s_reg[0], LINK.reset_pin};
	end

	// Serial state machine
	always_ff @(posedge I_CORE_CLK) begin
		if (hard_rst || cs_rise || !cs_low) begin
			state_reg     <= ST_CTRL;
			bit_cnt_reg   <= 6'd0;
			shift_reg     <= 32'h0;
			addr_reg      <= 5'h00;
			oe_reg        <= 1'b0;
			sdo_reg       <= 1'b1;
			crc_phase_reg <= 1'b0;
			rd_crc_reg    <= afs_pkg::CRC_SEED;
		end else begin
			case (state_reg)
				ST_CTRL: begin
					oe_reg <= 1'b0;
					if (sck_rise) begin
						shift_reg   <= {shift_reg[30:0], sdi_s_reg[1]};
						bit_cnt_reg <= bit_cnt_reg + 6'd1;
						if (bit_cnt_reg == 6'(afs_pkg::CTRL_BITS - 1)) begin
							bit_cnt_reg <= 6'd0;
							addr_reg    <= shift_reg[4:0];
							if (shift_reg[6:5] != afs_pkg::DEV_ADDR_RST) begin
								state_reg <= ST_IDLE;
							end else if (sdi_s_reg[1]) begin
								state_reg <= ST_READ;
								shift_reg <= {regs_reg[shift_reg[4:0]], 8'h00} >>
									(6'd32 - word_bits) << (6'd32 - word_bits);
							end else begin
								state_reg <= ST_WRITE;
							end
						end
					end
				end
				ST_READ: begin
					if (sck_fall) begin
						oe_reg  <= 1'b1;
						sdo_reg <= shift_reg[31];
						if (!crc_phase_reg) begin
							rd_crc_reg <= crc_bit(rd_crc_reg, shift_reg[31]);
						end
						shift_reg   <= {shift_reg[30:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 6'd1;
						if (bit_cnt_reg == word_bits - 6'd1 && !crc_phase_reg) begin
							bit_cnt_reg <= 6'd0;
							addr_reg    <= next_addr(addr_reg, sc[afs_pkg::POS_READ +: 2]);
							if (sc[afs_pkg::POS_CRC_EN] &&
								next_addr(addr_reg, sc[afs_pkg::POS_READ +: 2]) <= addr_reg) begin
								crc_phase_reg <= 1'b1;
								shift_reg     <= {crc_bit(rd_crc_reg, shift_reg[31]), 16'h0};
							end else begin
								shift_reg <= {regs_reg[next_addr(addr_reg,
									sc[afs_pkg::POS_READ +: 2])], 8'h00};
							end
						end else if (bit_cnt_reg == 6'd15 && crc_phase_reg) begin
							bit_cnt_reg   <= 6'd0;
							crc_phase_reg <= 1'b0;
							rd_crc_reg    <= afs_pkg::CRC_SEED;
							shift_reg     <= {regs_reg[addr_reg], 8'h00};
						end
					end
				end
				ST_WRITE: begin
					oe_reg <= 1'b0;
					if (sck_rise) begin
						shift_reg   <= {shift_reg[30:0], sdi_s_reg[1]};
						bit_cnt_reg <= bit_cnt_reg + 6'd1;
						if (bit_cnt_reg == word_bits - 6'd1) begin
							bit_cnt_reg <= 6'd0;
							if (addr_reg >= afs_pkg::ADDR_FIRST_WR &&
								(key_reg == afs_pkg::KEY_PASSWORD ||
								addr_reg == afs_pkg::ADDR_KEY_CRC)) begin
								addr_reg <= next_addr(addr_reg,
									sc[afs_pkg::POS_WRITE] ? 2'h2 : 2'h0);
							end
						end
					end
				end
				default: begin
					oe_reg <= 1'b0;
				end
			endcase
		end
	end

	// Register file; writes land on the last word bit
	always_ff @(posedge I_CORE_CLK) begin
		if (hard_rst) begin
			for (int i = 0; i < afs_pkg::REG_COUNT; i++) begin
				regs_reg[i] <= 24'h0;
			end
			regs_reg[afs_pkg::ADDR_STATUS_AND_COMM_SETTINGS] <= afs_pkg::STATUS_AND_COMM_SETTINGS_RST;
			key_reg <= afs_pkg::KEY_RST;
		end else begin
			if (I_ADC_NEW) begin
				for (int i = 0; i < 8; i++) begin
					regs_reg[i] <= I_ADC_DATA[i];
				end
			end
			regs_reg[afs_pkg::ADDR_KEY_CRC] <= {key_reg, cfg_crc_reg};
			if (state_reg == ST_WRITE && cs_low && sck_rise &&
				bit_cnt_reg == word_bits - 6'd1 && addr_reg >= afs_pkg::ADDR_FIRST_WR) begin
				if (addr_reg == afs_pkg::ADDR_KEY_CRC) begin
					key_reg <= shift_reg[word_bits - 6'd2 -: 8];
				end else if (key_reg == afs_pkg::KEY_PASSWORD) begin
					regs_reg[addr_reg] <= 24'({shift_reg[30:0], sdi_s_reg[1]} >>
						(word_bits - 6'd24));
				end
			end
		end
	end

	// Background checksum covers registers 9..30 and the key, recomputed whole every cycle
	always_comb begin
		crc_next = crc_reg;
		for (int i = 9; i < 31; i++) begin
			for (int b = 23; b >= 0; b--) begin
				crc_next = crc_bit(crc_next, regs_reg[i][b]);
			end
		end
		crc_next = crc_bit(crc_next, 1'b0) ^ {8'h00, key_reg};
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (hard_rst) begin
			crc_reg          <= afs_pkg::CRC_SEED;
			cfg_crc_reg      <= afs_pkg::CRC_SEED;
			cfg_crc_prev_reg <= afs_pkg::CRC_SEED;
			alert_reg        <= 1'b0;
		end else begin
			crc_reg          <= afs_pkg::CRC_SEED;
			cfg_crc_reg      <= crc_next;
			cfg_crc_prev_reg <= cfg_crc_reg;
			if (sc[afs_pkg::POS_ALERT_EN] && cfg_crc_reg != cfg_crc_prev_reg) begin
				alert_reg <= 1'b1;
			end else if (!sc[afs_pkg::POS_ALERT_EN]) begin
				alert_reg <= 1'b0;
			end
		end
	end

	// Ready pin: one-cycle low pulse per new result, held low on alert
	always_ff @(posedge I_CORE_CLK) begin
		if (hard_rst) begin
			ready_pulse_reg <= 1'b1;
		end else begin
			ready_pulse_reg <= ~(I_ADC_NEW | alert_reg);
		end
	end

	assign LINK.sdo              = sdo_reg;
	assign LINK.sdo_oe           = oe_reg & cs_low;
	assign LINK.data_ready_pin_n = ready_pulse_reg;
endmodule : afs_device

// ---- src/afs_host.sv ----
// Host end: SPI master issuing one control byte and a word stream
module afs_host #(
	parameter int SCK_HALF = 4
) (
	// Clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RESET,
	// Command
	input  wire logic        I_START,
	input  wire logic [7:0]  I_CTRL,
	input  wire logic [5:0]  I_WORD_BITS,
	input  wire logic [3:0]  I_WORDS,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_CPOL,
	input  wire logic        I_HARD_RESET,
	// Answer
	output logic             O_BUSY,
	output logic [31:0]      O_RDATA,
	output logic             O_RVALID,
	output logic             O_READY_N,
	// Link
	afs_if.host              LINK
);
	typedef enum {H_IDLE, H_RUN, H_END} afs_hstate_t;
	afs_hstate_t state_reg;
	logic [7:0]  div_reg;
	logic        sck_reg, cs_reg, sdi_reg, pol_reg;
	logic [5:0]  bit_reg;
	logic [3:0]  word_reg;
	logic        ctrl_phase_reg;
	logic [31:0] tx_reg, rx_reg;
	logic [1:0]  sdo_s_reg, dr_s_reg;

	always_ff @(posedge I_CORE_CLK) begin
		sdo_s_reg <= {sdo_s_reg[0], LINK.sdo};
		dr_s_reg  <= {dr_s_reg[0], LINK.data_ready_pin_n};
		O_READY_N <= dr_s_reg[1];
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			state_reg <= H_IDLE;
			div_reg <= 8'h00;
			sck_reg <= 1'b0;
			cs_reg <= 1'b1;
			sdi_reg <= 1'b0;
			pol_reg <= 1'b0;
			bit_reg <= 6'd0;
			word_reg <= 4'h0;
			ctrl_phase_reg <= 1'b1;
			tx_reg <= 32'h0;
			rx_reg <= 32'h0;
			O_BUSY <= 1'b0;
			O_RDATA <= 32'h0;
			O_RVALID <= 1'b0;
		end else begin
			O_RVALID <= 1'b0;
			case (state_reg)
				H_IDLE: begin
					sck_reg <= I_CPOL;
					pol_reg <= I_CPOL;
					if (I_START) begin
						cs_reg <= 1'b0;
						O_BUSY <= 1'b1;
						tx_reg <= {I_CTRL, 24'h0};
						sdi_reg <= I_CTRL[7];
						bit_reg <= 6'd0;
						word_reg <= 4'h0;
						ctrl_phase_reg <= 1'b1;
						div_reg <= 8'h00;
						state_reg <= H_RUN;
					end
				end
				H_RUN: begin
					div_reg <= div_reg + 8'h01;
					if (div_reg == 8'(SCK_HALF - 1)) begin
						div_reg <= 8'h00;
						sck_reg <= ~sck_reg;
						if (!sck_reg) begin
							// Rising edge: sample and count
							rx_reg <= {rx_reg[30:0], sdo_s_reg[1]};
							bit_reg <= bit_reg + 6'd1;
							tx_reg <= {tx_reg[30:0], 1'b0};
							if (ctrl_phase_reg && bit_reg == 6'd7) begin
								ctrl_phase_reg <= 1'b0;
								bit_reg <= 6'd0;
								rx_reg <= 32'h0;
								tx_reg <= I_WDATA << (6'd32 - I_WORD_BITS);
							end else if (!ctrl_phase_reg && bit_reg == I_WORD_BITS - 6'd1) begin
								bit_reg <= 6'd0;
								O_RDATA <= {rx_reg[30:0], sdo_s_reg[1]};
								rx_reg <= 32'h0;
								O_RVALID <= 1'b1;
								word_reg <= word_reg + 4'h1;
								tx_reg <= I_WDATA << (6'd32 - I_WORD_BITS);
								if (word_reg + 4'h1 == I_WORDS) begin
									state_reg <= H_END;
								end
							end
						end else begin
							// Falling edge: next bit out
							sdi_reg <= tx_reg[31];
						end
					end
				end
				default: begin
					sck_reg <= pol_reg;
					cs_reg <= 1'b1;
					O_BUSY <= 1'b0;
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	assign LINK.sck       = sck_reg;
	assign LINK.cs_n      = cs_reg;
	assign LINK.sdi       = sdi_reg;
	assign LINK.reset_pin = I_HARD_RESET;
endmodule : afs_host

// ---- tb/afs_monitor.sv ----
// Link checker for the serial host interface
module afs_monitor (
	input wire logic I_CORE_CLK,
	input wire logic I_RESET,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic data_ready_pin_n,
	input wire logic reset_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       sck_reg;
	logic [7:0] bit_cnt_reg;
	logic [7:0] ctrl_reg;
	logic       rise;
	logic       is_rd;
	logic       is_wr;
	logic       hit;
	assign rise  = sck && !sck_reg;
	assign is_rd = !cs_n && bit_cnt_reg >= 8'h08 && ctrl_reg[0];
	assign is_wr = !cs_n && bit_cnt_reg >= 8'h08 && !ctrl_reg[0];
	assign hit   = ctrl_reg[7:6] == afs_pkg::DEV_ADDR_RST;
	always_ff @(posedge I_CORE_CLK) begin
		sck_reg <= sck;
	end
	// Frame bit count and control byte as seen on the wire
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET || cs_n) begin
			bit_cnt_reg <= 8'h00;
		end else if (rise && bit_cnt_reg != 8'hFF) begin
			bit_cnt_reg <= bit_cnt_reg + 8'h01;
			if (bit_cnt_reg < 8'h08) begin
				ctrl_reg <= {ctrl_reg[6:0], sdi};
			end
		end
	end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RESET);
	a_idle_hiz: assert property (cs_n [*6] |-> !sdo_oe)
		else $error("output driven while deselected");
	a_ctrl_hiz: assert property (bit_cnt_reg inside {[1:7]} |-> !sdo_oe)
		else $error("output driven in control byte");
	a_write_hiz: assert property (is_wr |-> !sdo_oe)
		else $error("output driven in write");
	a_addr_miss: assert property ((is_rd && !hit) |-> !sdo_oe)
		else $error("foreign chip address answered");
	a_read_drive: assert property ((is_rd && hit && bit_cnt_reg == 8'h09) |-> sdo_oe)
		else $error("read not answered");
	a_sdo_on_fall: assert property ((sdo_oe && $past(sdo_oe) && !$stable(sdo)) |-> !sck)
		else $error("output changed outside clock low phase");
	a_cs_abort: assert property ($rose(cs_n) |-> ##[1:5] !sdo_oe)
		else $error("output held after frame end");
	a_pin_reset: assert property (reset_pin [*4] |-> !sdo_oe && data_ready_pin_n)
		else $error("reset pin not obeyed");
	a_core_reset: assert property ($fell(I_RESET) |-> !sdo_oe && data_ready_pin_n)
		else $error("outputs not at defaults after reset");
	c_read: cover property (is_rd && hit && bit_cnt_reg == 8'h09);
	c_write: cover property (is_wr && hit);
	c_ready: cover property ($fell(data_ready_pin_n));
endmodule : afs_monitor

// ---- tb/afs_tb_top.sv ----
// Bench joining host and device ends
module afs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [31:0] val; logic [31:0] msk;} afs_note_t;
	localparam logic [31:0] FULL = 32'hFFFF_FFFF;
	logic        clk;
	logic        rst;
	logic        start;
	logic [7:0]  ctrl;
	logic [3:0]  words;
	logic [31:0] wdata;
	logic        cpol;
	logic        hard_rst;
	logic        busy;
	logic [31:0] rdata;
	logic        rvalid;
	logic        ready_n;
	logic [23:0] adc [8];
	logic        adc_new;
	logic        rd_frame;
	logic [31:0] wd;
	int          error_cnt;
	int          n_compared;
	int          seed;
	int          k;
	afs_note_t   notes[$];
	afs_note_t   cur;
	afs_if link();
	afs_device afs_device_i (.I_CORE_CLK(clk), .I_RESET(rst), .I_ADC_DATA(adc),
		.I_ADC_NEW(adc_new), .LINK(link));
	afs_host #(.SCK_HALF(6)) afs_host_i (.I_CORE_CLK(clk), .I_RESET(rst), .I_START(start),
		.I_CTRL(ctrl), .I_WORD_BITS(6'h18), .I_WORDS(words), .I_WDATA(wdata), .I_CPOL(cpol),
		.I_HARD_RESET(hard_rst), .O_BUSY(busy), .O_RDATA(rdata), .O_RVALID(rvalid),
		.O_READY_N(ready_n), .LINK(link));
	afs_monitor afs_monitor_i (.I_CORE_CLK(clk), .I_RESET(rst), .sck(link.sck),
		.cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
		.data_ready_pin_n(link.data_ready_pin_n), .reset_pin(link.reset_pin));
	always #25 clk = ~clk;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : cmp
	function automatic void note(input logic [31:0] v, input logic [31:0] m);
		notes.push_back('{v, m});
	endfunction : note
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// One frame; mode picked at random while deselected
	task automatic frame(input logic [1:0] chip, input logic [4:0] idx, input logic rd,
			input logic [3:0] n, input logic [31:0] d);
		@(negedge clk);
		ctrl = {chip, idx, rd};
		words = n;
		wdata = d;
		cpol = 1'($random(seed));
		rd_frame = rd && chip == afs_pkg::DEV_ADDR_RST;
		@(negedge clk);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (k = 0; k < 8000 && busy !== 1'b0; k++)
			@(negedge clk);
		if (busy !== 1'b0 || notes.size() != 0) begin
			error_cnt++;
			$display("[ERR] %0t frame hung or words missing", $time);
		end
		notes.delete();
		rd_frame = 1'b0;
		repeat (4) @(negedge clk);
	endtask : frame
	task automatic ready_low(input logic exp);
		for (k = 0; k < 60 && ready_n !== exp; k++)
			@(negedge clk);
		cmp({31'h0, ready_n}, {31'h0, exp});
	endtask : ready_low
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rd_frame) begin
			if (notes.size() == 0) begin
				error_cnt++;
				$display("[ERR] %0t unexpected word", $time);
			end else begin
				cur = notes.pop_front();
				cmp(rdata & cur.msk, cur.val & cur.msk);
			end
		end
	end
	initial begin
		#(100000 * 50);
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		report_and_stop();
	end
	initial begin
		seed = 4;
		clk = 0;
		rst = 1;
		{start, ctrl, words, wdata, cpol, hard_rst, adc_new, rd_frame} = '0;
		foreach (adc[i]) adc[i] = 24'h0;
		repeat (2) @(negedge clk);
		rst = 0;
		note({8'h0, afs_pkg::STATUS_AND_COMM_SETTINGS_RST}, FULL);
		frame(2'h1, afs_pkg::ADDR_STATUS_AND_COMM_SETTINGS, 1'b1, 4'h1, 32'h0);
		note({8'h0, afs_pkg::KEY_RST, 16'h0}, 32'h00FF_0000);
		frame(2'h1, afs_pkg::ADDR_KEY_CRC, 1'b1, 4'h1, 32'h0);
		$display("test reset values done");
		foreach (adc[i]) adc[i] = 24'($random(seed));
		adc_new = 1'b1;
		@(negedge clk);
		adc_new = 1'b0;
		ready_low(1'b0);
		foreach (adc[i]) note({8'h0, adc[i]}, FULL);
		note({8'h0, adc[0]}, FULL);
		frame(2'h1, 5'h00, 1'b1, 4'h9, 32'h0);
		$display("test result loop done");
		wd = {8'h0, 24'($random(seed))};
		frame(2'h1, 5'h09, 1'b0, 4'h1, wd);
		frame(2'h1, 5'h05, 1'b0, 4'h1, ~wd);
		note(wd, FULL);
		frame(2'h1, 5'h09, 1'b1, 4'h1, 32'h0);
		note({8'h0, adc[5]}, FULL);
		frame(2'h1, 5'h05, 1'b1, 4'h1, 32'h0);
		frame(2'h1, afs_pkg::ADDR_KEY_CRC, 1'b0, 4'h1, 32'h0);
		frame(2'h1, 5'h09, 1'b0, 4'h1, ~wd);
		note(wd, FULL);
		frame(2'h1, 5'h09, 1'b1, 4'h1, 32'h0);
		frame(2'h1, afs_pkg::ADDR_KEY_CRC, 1'b0, 4'h1, 32'h00A5_0000);
		frame(2'h2, 5'h09, 1'b0, 4'h1, ~wd);
		frame(2'h2, 5'h09, 1'b1, 4'h1, 32'h0);
		note(wd, FULL);
		frame(2'h1, 5'h09, 1'b1, 4'h1, 32'h0);
		$display("test write guard done");
		frame(2'h1, afs_pkg::ADDR_STATUS_AND_COMM_SETTINGS, 1'b0, 4'h1, 32'h0081_4000);
		frame(2'h1, 5'h09, 1'b0, 4'h1, ~wd);
		ready_low(1'b0);
		$display("test config alert done");
		hard_rst = 1'b1;
		repeat (6) @(negedge clk);
		hard_rst = 1'b0;
		ready_low(1'b1);
		note({8'h0, afs_pkg::STATUS_AND_COMM_SETTINGS_RST}, FULL);
		frame(2'h1, afs_pkg::ADDR_STATUS_AND_COMM_SETTINGS, 1'b1, 4'h1, 32'h0);
		$display("test hard reset done");
		report_and_stop();
	end
endmodule : afs_tb_top
